// ---- hdl/ccr_pkg.sv ----
package ccr_pkg;

  // ----------------------------------------------------------------
  // Register map (index kept, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL = 8'h00;
  localparam logic [7:0] IDX_RESULT = 8'h01;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h02;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h03;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h04;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = ADDR_W'(4 * IDX_CONTROL);
  localparam logic [ADDR_W-1:0] ADDR_RESULT = ADDR_W'(4 * IDX_RESULT);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = ADDR_W'(4 * IDX_IRQ_STATUS);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = ADDR_W'(4 * IDX_IRQ_CLEAR);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = ADDR_W'(4 * IDX_IRQ_ENABLE);

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CONTROL_W = 8;
  localparam int RESULT_W = 16;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 2;
  localparam logic [MODE_W-1:0] MODE_CONTINUOUS = 2'h3;
  localparam logic [CONTROL_W-1:0] CONTROL_RESET = 8'h00;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
  localparam int IRQ_READY_BIT = 0;
  localparam int IRQ_DISCARD_BIT = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int CORRECTION_PERIOD_NS = 1000;
  localparam int CORRECTION_CYCLES =
    (CORRECTION_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONVERSION_CYCLES = 64;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h1,
    ST_CONVERT = 3'h2,
    ST_CORRECT = 3'h4
  } ccr_state_type;

  typedef struct packed
  {
    logic discard;
    logic ready;
  } ccr_irq_type;

endpackage : ccr_pkg

// ---- hdl/ccr_top.sv ----
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
// Behaviour
// - At each finished conversion the ready pin falls from high to low.
// - Reading result index 0x1 returns the ready pin high; conversion continues.
// - While a presented result stays unread the ready pin stays low.
// - Unread result: pin rises at next raw conversion end, old result discarded.
// - After the raw end, wait the correction period, then pin falls again.
// - Every unread newer result is discarded likewise; only the latest is kept.
module ccr_top #(
  parameter int CONV_CYCLES = ccr_pkg::CONVERSION_CYCLES
) (
  input wire logic clk_sys, // System clock, 10 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic [ccr_pkg::RESULT_W-1:0] raw_sample, // Modulator word at raw end
  input wire logic [ccr_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ccr_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic serial_out_ready_low, // Low while a new result waits
  output logic irq // Level interrupt
);

  localparam int CAL_N = ccr_pkg::CORRECTION_CYCLES;
  // Pin is sampled high on the two edges after the raw end and low one edge after the correction window ends
  localparam int CAL_GAP = CAL_N - 1;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [ccr_pkg::CONTROL_W-1:0] control_r;
  logic [ccr_pkg::RESULT_W-1:0] result_r;
  logic [ccr_pkg::RESULT_W-1:0] raw_hold_r;
  ccr_pkg::ccr_irq_type status_r;
  ccr_pkg::ccr_irq_type enable_r;
  ccr_pkg::ccr_state_type state_r;
  logic [15:0] conv_cnt_r;
  logic [15:0] cal_cnt_r;
  logic pending_r;
  logic [ccr_pkg::ADDR_W-1:0] awaddr_r;
  logic aw_have_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_have_r;

  logic continuous;
  logic raw_end;
  logic corr_done;
  logic wr_go;
  logic rd_go;
  logic rd_result;
  ccr_pkg::ccr_irq_type clear_bits;
  logic irq_src;

  assign continuous = control_r[ccr_pkg::MODE_LSB +: ccr_pkg::MODE_W] == ccr_pkg::MODE_CONTINUOUS;
  assign raw_end = (state_r != ccr_pkg::ST_IDLE) && (conv_cnt_r == 16'(CONV_CYCLES - 1));
  assign corr_done = (state_r == ccr_pkg::ST_CORRECT) && (cal_cnt_r == 16'(CAL_N - 1));
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_result = rd_go && (s_axi_araddr == ccr_pkg::ADDR_RESULT);
  assign clear_bits = (wr_go && awaddr_r == ccr_pkg::ADDR_IRQ_CLEAR && wstrb_r[0])
    ? ccr_pkg::ccr_irq_type'(wdata_r[ccr_pkg::IRQ_W-1:0]) : '0;
  // Registered below so the interrupt pin comes straight off a flip-flop, one cycle late
  assign irq_src = |(status_r & enable_r);

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data are taken in either order and held until both are in
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ccr_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_r)
          ccr_pkg::ADDR_CONTROL, ccr_pkg::ADDR_IRQ_CLEAR, ccr_pkg::ADDR_IRQ_ENABLE:
            s_axi_bresp <= ccr_pkg::RESP_OKAY;
          default:
            s_axi_bresp <= ccr_pkg::RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      control_r <= ccr_pkg::CONTROL_RESET;
      enable_r <= '0;
    end
    else if (wr_go && wstrb_r[0])
    begin
      if (awaddr_r == ccr_pkg::ADDR_CONTROL)
        control_r <= wdata_r[ccr_pkg::CONTROL_W-1:0];
      if (awaddr_r == ccr_pkg::ADDR_IRQ_ENABLE)
        enable_r <= ccr_pkg::ccr_irq_type'(wdata_r[ccr_pkg::IRQ_W-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ccr_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ccr_pkg::RESP_OKAY;
        case (s_axi_araddr)
          ccr_pkg::ADDR_CONTROL: s_axi_rdata <= 32'(control_r);
          ccr_pkg::ADDR_RESULT: s_axi_rdata <= 32'(result_r);
          ccr_pkg::ADDR_IRQ_STATUS: s_axi_rdata <= 32'(status_r);
          ccr_pkg::ADDR_IRQ_ENABLE: s_axi_rdata <= 32'(enable_r);
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= ccr_pkg::RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // The modulator keeps converting while a result waits; the host must read
  // before the next raw conversion end, the conversion period less the correction period, or the result is lost.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_r <= ccr_pkg::ST_IDLE;
      conv_cnt_r <= 16'h0000;
      cal_cnt_r <= 16'h0000;
      raw_hold_r <= ccr_pkg::RESULT_RESET;
    end
    else
    begin
      if (state_r == ccr_pkg::ST_IDLE || raw_end)
        conv_cnt_r <= 16'h0000;
      else
        conv_cnt_r <= conv_cnt_r + 16'h0001;
      if (raw_end)
        raw_hold_r <= raw_sample;
      unique case (state_r)
        ccr_pkg::ST_IDLE:
          if (continuous)
            state_r <= ccr_pkg::ST_CONVERT;
        ccr_pkg::ST_CONVERT:
          if (raw_end)
          begin
            state_r <= ccr_pkg::ST_CORRECT;
            cal_cnt_r <= 16'h0000;
          end
          else if (!continuous)
            state_r <= ccr_pkg::ST_IDLE;
        ccr_pkg::ST_CORRECT:
          // Correction always runs to its end so every result gets the same delay
          if (corr_done)
            state_r <= continuous ? ccr_pkg::ST_CONVERT : ccr_pkg::ST_IDLE;
          else
            cal_cnt_r <= cal_cnt_r + 16'h0001;
        // A corrupted state code falls back to idle
        default:
          state_r <= ccr_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result register and ready pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      result_r <= ccr_pkg::RESULT_RESET;
      pending_r <= 1'b0;
      serial_out_ready_low <= 1'b1;
    end
    else if (corr_done)
    begin
      result_r <= raw_hold_r;
      pending_r <= 1'b1;
      serial_out_ready_low <= 1'b0;
    end
    else if (raw_end && pending_r)
    begin
      pending_r <= 1'b0;
      serial_out_ready_low <= 1'b1;
    end
    else if (rd_result)
    begin
      pending_r <= 1'b0;
      serial_out_ready_low <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      status_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      status_r.ready <= corr_done || (status_r.ready && !clear_bits.ready);
      status_r.discard <= (raw_end && pending_r) || (status_r.discard && !clear_bits.discard);
      irq <= irq_src;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ready_fall_a: assert property (@(posedge clk_sys) disable iff (reset)
    corr_done |=> !serial_out_ready_low && pending_r)
    else $error("ready pin did not fall after correction");

  read_release_a: assert property (@(posedge clk_sys) disable iff (reset)
    (rd_result && !corr_done) |=> serial_out_ready_low)
    else $error("ready pin not released after result read");

  hold_low_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!serial_out_ready_low && !rd_result && !raw_end) |=> !serial_out_ready_low)
    else $error("ready pin rose while result unread");

  discard_raise_a: assert property (@(posedge clk_sys) disable iff (reset)
    (raw_end && pending_r) |=> serial_out_ready_low && status_r.discard)
    else $error("unread result not discarded at raw end");

  corr_wait_a: assert property (@(posedge clk_sys) disable iff (reset)
    raw_end |=> serial_out_ready_low [*2] ##CAL_GAP !serial_out_ready_low)
    else $error("ready pin timing after raw end wrong");

  latest_kept_a: assert property (@(posedge clk_sys) disable iff (reset)
    corr_done |=> result_r == $past(raw_hold_r))
    else $error("result register does not hold latest conversion");

  corr_fixed_a: assert property (@(posedge clk_sys) disable iff (reset)
    raw_end |-> ##CAL_N corr_done)
    else $error("correction period not fixed");

  mode_start_a: assert property (@(posedge clk_sys) disable iff (reset)
    (state_r == ccr_pkg::ST_IDLE && continuous) |=> state_r == ccr_pkg::ST_CONVERT)
    else $error("continuous mode did not start converting");

  irq_level_a: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 irq == $past(irq_src))
    else $error("interrupt level mismatch");

  bresp_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  rdata_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");

  aw_refuse_a: assert property (@(posedge clk_sys) disable iff (reset)
    aw_have_r |-> !s_axi_awready)
    else $error("write address accepted while one is held");

  result_stable_a: assert property (@(posedge clk_sys) disable iff (reset)
    !corr_done |=> $stable(result_r))
    else $error("result register changed outside correction end");

  result_seen_c: cover property (@(posedge clk_sys) disable iff (reset) corr_done);
  result_read_c: cover property (@(posedge clk_sys) disable iff (reset) rd_result && pending_r);
  discard_c: cover property (@(posedge clk_sys) disable iff (reset) raw_end && pending_r);
  irq_seen_c: cover property (@(posedge clk_sys) disable iff (reset) irq);
  mode_stop_c: cover property (@(posedge clk_sys) disable iff (reset)
    state_r == ccr_pkg::ST_CONVERT && !continuous);

endmodule : ccr_top

// ---- sim/ccr_host.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host controller: register-bus master
// ------------------------------------------------------------
module ccr_host (
  input wire logic clk_sys, // System clock
  output logic [7:0] awaddr, // Write address
  output logic awvalid, // Write address valid
  input wire logic awready, // Write address ready
  output logic [31:0] wdata, // Write data
  output logic [3:0] wstrb, // Write strobes
  output logic wvalid, // Write data valid
  input wire logic wready, // Write data ready
  input wire logic [1:0] bresp, // Write response
  input wire logic bvalid, // Write response valid
  output logic bready, // Write response ready
  output logic [7:0] araddr, // Read address
  output logic arvalid, // Read address valid
  input wire logic arready, // Read address ready
  input wire logic [31:0] rdata, // Read data
  input wire logic [1:0] rresp, // Read response
  input wire logic rvalid, // Read data valid
  output logic rready // Read data ready
);
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = 47'h0;
    {araddr, arvalid, rready} = 10'h0;
  end

  // Address and data are each held until their own ready is sampled high; bready and rready until the response valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'h7;
    forever
    begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    forever
    begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
endmodule : ccr_host

// ---- sim/continuous_conv_ready_flow_tb.sv ----
`timescale 1ns/1ps
module continuous_conv_ready_flow_tb;
  // Longer than the smallest safe value so a read fits after the pin falls
  localparam int CONV_N = 32;
  localparam int CAL_N = ccr_pkg::CORRECTION_CYCLES;
  logic clk_sys, reset, irq, serial_out_ready_low, pin_q;
  logic [15:0] raw_sample, exp_res;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int miscompares, n_tests, cycles, n;

  ccr_top #(.CONV_CYCLES(CONV_N)) DUT (
    .clk_sys(clk_sys), .reset(reset), .raw_sample(raw_sample),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_out_ready_low(serial_out_ready_low), .irq(irq)
  );
  ccr_host HOST (
    .clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_pin(input logic v);
    int k;
    k = 0;
    while (serial_out_ready_low !== v && k < 200)
    begin
      @(posedge clk_sys);
      k++;
    end
    chk(32'(serial_out_ready_low), 32'(v));
  endtask : wait_pin

  task automatic count_level(input logic v, output int c);
    c = 1;
    forever
    begin
      @(posedge clk_sys);
      if (serial_out_ready_low !== v || c > 200) break;
      c++;
    end
  endtask : count_level

  task automatic tally_and_finish();
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // Modulator source and timeout
  // ------------------------------------------------------------
  // A new sample is offered only after a result is presented, so the expected word is known
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    pin_q <= serial_out_ready_low;
    if (pin_q === 1'b1 && serial_out_ready_low === 1'b0)
    begin
      exp_res <= raw_sample;
      raw_sample <= 16'($urandom);
    end
    if (cycles == 6000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial
  begin
    reset = 1'b1;
    raw_sample = 16'h0000;
    exp_res = 16'h0000;
    n = $urandom(32'hA729);
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    HOST.rd(ccr_pkg::ADDR_CONTROL, rd, rsp);
    chk(rd, {24'h000000, ccr_pkg::CONTROL_RESET});
    HOST.rd(ccr_pkg::ADDR_RESULT, rd, rsp);
    chk(rd, {16'h0000, ccr_pkg::RESULT_RESET});
    chk({30'h0, serial_out_ready_low, irq}, 32'h2);
    HOST.wr(ccr_pkg::ADDR_IRQ_ENABLE, 32'h1, rsp);
    HOST.wr(ccr_pkg::ADDR_CONTROL, {30'h0, ccr_pkg::MODE_CONTINUOUS}, rsp);
    HOST.rd(ccr_pkg::ADDR_CONTROL, rd, rsp);
    chk(rd, 32'h3);
    repeat (4)
    begin
      wait_pin(1'b0);
      @(posedge clk_sys);
      chk(32'(irq), 32'h1);
      repeat ($urandom_range(0, 3)) @(posedge clk_sys);
      HOST.rd(ccr_pkg::ADDR_RESULT, rd, rsp);
      chk(rd, {16'h0000, exp_res});
      chk(32'(serial_out_ready_low), 32'h1);
      HOST.wr(ccr_pkg::ADDR_IRQ_CLEAR, 32'h3, rsp);
      repeat (2) @(posedge clk_sys);
      chk(32'(irq), 32'h0);
    end
    HOST.wr(ccr_pkg::ADDR_IRQ_ENABLE, 32'h0, rsp);
    wait_pin(1'b0);
    wait_pin(1'b1);
    repeat (3)
    begin
      count_level(1'b1, n);
      chk(32'(n), 32'(CAL_N));
      count_level(1'b0, n);
      chk(32'(n), 32'(CONV_N - CAL_N));
    end
    wait_pin(1'b0);
    HOST.rd(ccr_pkg::ADDR_RESULT, rd, rsp);
    chk(rd, {16'h0000, exp_res});
    HOST.rd(ccr_pkg::ADDR_IRQ_STATUS, rd, rsp);
    chk(32'(rd[ccr_pkg::IRQ_DISCARD_BIT]), 32'h1);
    chk(32'(irq), 32'h0);
    HOST.rd(8'h40, rd, rsp);
    chk({rd[29:0], rsp}, {30'h0, ccr_pkg::RESP_SLVERR});
    HOST.wr(ccr_pkg::ADDR_RESULT, 32'h5A, rsp);
    chk(32'(rsp), 32'(ccr_pkg::RESP_SLVERR));
    HOST.wr(ccr_pkg::ADDR_IRQ_STATUS, 32'h3, rsp);
    chk(32'(rsp), 32'(ccr_pkg::RESP_SLVERR));
    HOST.rd(ccr_pkg::ADDR_IRQ_ENABLE, rd, rsp);
    chk(rd, 32'h0);
    // Leaving continuous mode: a correction under way may still present one result
    HOST.wr(ccr_pkg::ADDR_CONTROL, 32'h0, rsp);
    HOST.rd(ccr_pkg::ADDR_CONTROL, rd, rsp);
    chk(rd, 32'h0);
    repeat (CONV_N + CAL_N + 4) @(posedge clk_sys);
    HOST.rd(ccr_pkg::ADDR_RESULT, rd, rsp);
    chk(rd, {16'h0000, exp_res});
    repeat (CONV_N + 4) @(posedge clk_sys);
    chk(32'(serial_out_ready_low), 32'h1);
    tally_and_finish();
  end
endmodule : continuous_conv_ready_flow_tb
